/* logic/asfc_cfg.svh */
// Register addresses, field positions, reset values and timing counts
`ifndef ASFC_CFG_SVH
`define ASFC_CFG_SVH
`define ASFC_SW_ADDR      16'hFF4F
`define ASFC_MODE_ADDR    16'hFF50
`define ASFC_TXB_ADDR     16'hFF51
`define ASFC_RXB_ADDR     16'hFF52
`define ASFC_ERR_ADDR     16'hFF53
`define ASFC_SW_RESET     8'h00
`define ASFC_MODE_RESET   8'h00
`define ASFC_SW_MASK      8'h33
`define ASFC_M_POWER      7
`define ASFC_M_TXEN       6
`define ASFC_M_RXEN       5
`define ASFC_M_PAR_HI     4
`define ASFC_M_PAR_LO     3
`define ASFC_M_CHAR8      2
`define ASFC_M_STOP2      1
`define ASFC_M_ERR_ROUTE  0
`define ASFC_I_ROUTE_HI   5
`define ASFC_I_ROUTE_LO   4
`define ASFC_I_CAPT_SEL   1
`define ASFC_I_IRQ0_SEL   0
`define ASFC_E_PARITY     2
`define ASFC_E_FRAMING    1
`define ASFC_E_OVERRUN    0
`define ASFC_BIT_DIV      16
`endif

/* logic/asfc_pkg.sv */
// Types shared by the serial frame blocks
package asfc_pkg;
  // Parity modes, in the order of the two-bit field code
  typedef enum logic [1:0] {ASFC_PAR_NONE, ASFC_PAR_ZERO, ASFC_PAR_ODD,
                            ASFC_PAR_EVEN} asfc_par_t;
  // Frame sequencer states
  typedef enum logic [2:0] {ASFC_IDLE, ASFC_START, ASFC_DATA, ASFC_PAR,
                            ASFC_STOP} asfc_state_t;
endpackage

/* logic/asfc_rx.sv */
// Serial frame receiver: start detect, centre sampling, parity and stop check
`timescale 1ns/10ps
`include "asfc_cfg.svh"
module asfc_rx import asfc_pkg::*; #(
  parameter int BIT_DIV = `ASFC_BIT_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic       rx_line,
  input  wire logic       char8,
  input  asfc_par_t       par_mode,
  output logic            done_ff,
  output logic [7:0]      data_ff,
  output logic            par_err_ff,
  output logic            frm_err_ff
);
  localparam logic [15:0] FULL = 16'(BIT_DIV - 1);
  localparam logic [15:0] HALF = 16'(BIT_DIV / 2 - 1);

  asfc_state_t st_ff, nxt_st;          // Sequencer state
  logic [15:0] cnt_ff, nxt_cnt;        // Cycles within a bit
  logic [2:0]  bit_ff, nxt_bit;        // Data bit index
  logic        par_ff, nxt_par;        // Running xor of data
  logic        nxt_done, nxt_perr, nxt_ferr;
  logic [7:0]  nxt_data;

  // Next-state logic of the receiver
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff + 16'h0001;
    nxt_bit  = bit_ff;
    nxt_par  = par_ff;
    nxt_data = data_ff;
    nxt_done = 1'b0;
    nxt_perr = par_err_ff;
    nxt_ferr = frm_err_ff;
    if (!run)
    begin
      nxt_st  = ASFC_IDLE;               // Disabled: hold idle
      nxt_cnt = 16'h0000;
    end
    else
      case (st_ff)
        ASFC_IDLE:
        begin
          nxt_cnt = 16'h0000;
          if (!rx_line)
          begin
            nxt_st   = ASFC_START;
            nxt_par  = 1'b0;
            nxt_bit  = 3'h0;
            nxt_data = 8'h00;
          end
        end
        ASFC_START:
          if (cnt_ff == HALF)            // Centre of start bit
          begin
            nxt_cnt = 16'h0000;
            nxt_st  = rx_line ? ASFC_IDLE : ASFC_DATA;
          end
        ASFC_DATA:
          if (cnt_ff == FULL)
          begin
            nxt_cnt = 16'h0000;
            nxt_data[bit_ff] = rx_line;  // LSB first
            nxt_par = par_ff ^ rx_line;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == (char8 ? 3'h7 : 3'h6))
              nxt_st = (par_mode == ASFC_PAR_NONE) ? ASFC_STOP
                                                   : ASFC_PAR;
          end
        ASFC_PAR:
          if (cnt_ff == FULL)
          begin
            nxt_cnt = 16'h0000;
            nxt_st  = ASFC_STOP;
            // Zero parity is taken but never judged
            nxt_par = ((par_mode == ASFC_PAR_ODD)
                       && !(par_ff ^ rx_line))
                   || ((par_mode == ASFC_PAR_EVEN)
                       && (par_ff ^ rx_line));
          end
        ASFC_STOP:
          if (cnt_ff == FULL)            // Only one stop bit checked
          begin
            nxt_cnt  = 16'h0000;
            nxt_st   = ASFC_IDLE;
            nxt_done = 1'b1;
            nxt_ferr = !rx_line;
            nxt_perr = (par_mode == ASFC_PAR_ODD
                        || par_mode == ASFC_PAR_EVEN) && par_ff;
          end
        default:
          nxt_st = ASFC_IDLE;
      endcase
  end

  // Receiver state registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st_ff      <= ASFC_IDLE;
      cnt_ff     <= 16'h0000;
      bit_ff     <= 3'h0;
      par_ff     <= 1'b0;
      data_ff    <= 8'h00;
      done_ff    <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end
    else
    begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      bit_ff     <= nxt_bit;
      par_ff     <= nxt_par;
      data_ff    <= nxt_data;
      done_ff    <= nxt_done;
      par_err_ff <= nxt_perr;
      frm_err_ff <= nxt_ferr;
    end
  end
endmodule

/* logic/asfc_top.sv */
// Asynchronous serial frame unit with mode and input-switch registers
// Functional notes
// - Parity field: none, zero, odd, even
// - Zero parity never checked nor flagged
// - Length bit: seven or eight data bits
// - Stop select: one or two sent
// - Receiver checks exactly one stop bit
// - Routing bit picks error or complete interrupt
// - Low line at enable starts reception
// - Enables synchronised; re-enable two clocks later
// - Route field picks primary or alternate pins
// - Capture source: dedicated pin or receive line
// - Interrupt source: dedicated pin or receive line
// - Input switch register resets to zero
`timescale 1ns/10ps
`include "asfc_cfg.svh"
module asfc_top import asfc_pkg::*; #(
  parameter int BIT_DIV = `ASFC_BIT_DIV    // Base clocks per bit
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        reg_wr,           // Register write strobe
  input  wire logic        reg_rd,           // Register read strobe
  input  wire logic [15:0] reg_addr,         // Register address
  input  wire logic [7:0]  reg_wdata,        // Write data
  output logic [7:0]       reg_rdata_ff,     // Read data, one cycle later
  input  wire logic        primary_rx_pin,
  input  wire logic        alternate_rx_pin,
  input  wire logic        timer_capture_pin,
  input  wire logic        ext_irq0_pin,
  output logic             primary_tx_pin_ff,
  output logic             alternate_tx_pin_ff,
  output logic             timer_capture_input_ff,
  output logic             ext_irq0_input_ff,
  output logic             rx_complete_irq_ff,
  output logic             rx_error_irq_ff
);
  localparam logic [15:0] FULL = 16'(BIT_DIV - 1);

  // Register file state
  logic [7:0] mode_ff, nxt_mode;       // async_serial_mode
  logic [7:0] sw_ff, nxt_sw;           // input_switch_control
  logic [7:0] txb_ff, nxt_txb;         // tx_buffer
  logic       txb_full_ff, nxt_txb_full;
  logic [7:0] rxb_ff, nxt_rxb;         // Received byte
  logic       rxb_full_ff, nxt_rxb_full;
  logic [2:0] err_ff, nxt_err;         // rx_error_status
  logic [7:0] nxt_rdata;
  logic       nxt_cirq, nxt_eirq;
  // Enable synchronisers
  logic [1:0] txen_sync_ff, rxen_sync_ff;
  // Transmitter state
  asfc_state_t tst_ff, nxt_tst;
  logic [15:0] tcnt_ff, nxt_tcnt;
  logic [2:0]  tbit_ff, nxt_tbit;
  logic [7:0]  tsh_ff, nxt_tsh;
  logic        tpar_ff, nxt_tpar;
  logic        tstop_ff, nxt_tstop;    // Second stop bit pending
  logic        tline_ff, nxt_tline;
  logic        tx_load;
  // Pin routing
  logic        rx_line, nxt_ptx, nxt_atx, nxt_cap, nxt_irq0;
  // Receiver results
  logic        rx_done, rx_perr, rx_ferr;
  logic [7:0]  rx_data;
  logic        tx_run, rx_run;
  asfc_par_t   par_mode;

  // Decode of the two-bit route field
  function automatic logic alt_route(input logic [7:0] sw);
    alt_route = sw[`ASFC_I_ROUTE_LO];
  endfunction

  assign par_mode = asfc_par_t'({mode_ff[`ASFC_M_PAR_HI],
                                 mode_ff[`ASFC_M_PAR_LO]});
  assign tx_run = mode_ff[`ASFC_M_POWER] & txen_sync_ff[1];
  assign rx_run = mode_ff[`ASFC_M_POWER] & rxen_sync_ff[1];
  // Receive line from the routed pin; only the low route bit is decoded
  assign rx_line = alt_route(sw_ff) ? alternate_rx_pin
                                    : primary_rx_pin;

  // Receiver engine
  asfc_rx #(.BIT_DIV(BIT_DIV)) u_rx (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .run        (rx_run),
    .rx_line    (rx_line),
    .char8      (mode_ff[`ASFC_M_CHAR8]),
    .par_mode   (par_mode),
    .done_ff    (rx_done),
    .data_ff    (rx_data),
    .par_err_ff (rx_perr),
    .frm_err_ff (rx_ferr)
  );

  // Register writes, reads, receive results and interrupts
  always_comb
  begin
    nxt_mode     = mode_ff;
    nxt_sw       = sw_ff;
    nxt_txb      = txb_ff;
    nxt_txb_full = txb_full_ff && !tx_load && tx_run;
    nxt_rxb      = rxb_ff;
    nxt_rxb_full = rxb_full_ff;
    nxt_err      = err_ff;
    nxt_rdata    = 8'h00;
    nxt_cirq     = 1'b0;
    nxt_eirq     = 1'b0;
    if (reg_wr)
      case (reg_addr)
        `ASFC_MODE_ADDR: nxt_mode = reg_wdata;
        `ASFC_SW_ADDR:   nxt_sw   = reg_wdata & `ASFC_SW_MASK;
        `ASFC_TXB_ADDR:
          if (tx_run && !txb_full_ff)    // Ignored until enable seen
          begin
            nxt_txb      = reg_wdata;
            nxt_txb_full = 1'b1;
          end
        default: ;                       // Unmapped: ignored
      endcase
    if (reg_rd)
      case (reg_addr)
        `ASFC_MODE_ADDR: nxt_rdata = mode_ff;
        `ASFC_SW_ADDR:   nxt_rdata = sw_ff;
        `ASFC_TXB_ADDR:  nxt_rdata = {6'h00, txb_full_ff,
                                      tst_ff != ASFC_IDLE};
        `ASFC_RXB_ADDR:
        begin
          nxt_rdata    = rxb_ff;
          nxt_rxb_full = 1'b0;
        end
        `ASFC_ERR_ADDR:
        begin
          nxt_rdata = {5'h00, err_ff};
          nxt_err   = 3'h0;              // Read clears
        end
        default: nxt_rdata = 8'h00;
      endcase
    if (rx_done)                         // Set wins over read clear
    begin
      nxt_rxb = rx_data;
      nxt_err[`ASFC_E_PARITY]  = err_ff[`ASFC_E_PARITY] | rx_perr;
      nxt_err[`ASFC_E_FRAMING] = err_ff[`ASFC_E_FRAMING] | rx_ferr;
      nxt_err[`ASFC_E_OVERRUN] = err_ff[`ASFC_E_OVERRUN] | rxb_full_ff;
      nxt_rxb_full = 1'b1;
      // Error report goes to one interrupt only
      if ((rx_perr || rx_ferr || rxb_full_ff)
          && !mode_ff[`ASFC_M_ERR_ROUTE])
        nxt_eirq = 1'b1;
      else
        nxt_cirq = 1'b1;
    end
  end

  // Register file flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mode_ff            <= `ASFC_MODE_RESET;
      sw_ff              <= `ASFC_SW_RESET;
      txb_ff             <= 8'h00;
      txb_full_ff        <= 1'b0;
      rxb_ff             <= 8'h00;
      rxb_full_ff        <= 1'b0;
      err_ff             <= 3'h0;
      reg_rdata_ff       <= 8'h00;
      rx_complete_irq_ff <= 1'b0;
      rx_error_irq_ff    <= 1'b0;
      txen_sync_ff       <= 2'h0;
      rxen_sync_ff       <= 2'h0;
    end
    else
    begin
      mode_ff            <= nxt_mode;
      sw_ff              <= nxt_sw;
      txb_ff             <= nxt_txb;
      txb_full_ff        <= nxt_txb_full;
      rxb_ff             <= nxt_rxb;
      rxb_full_ff        <= nxt_rxb_full;
      err_ff             <= nxt_err;
      reg_rdata_ff       <= nxt_rdata;
      rx_complete_irq_ff <= nxt_cirq;
      rx_error_irq_ff    <= nxt_eirq;
      // Two-stage enable synchronisers to the base clock
      txen_sync_ff <= {txen_sync_ff[0], mode_ff[`ASFC_M_TXEN]};
      rxen_sync_ff <= {rxen_sync_ff[0], mode_ff[`ASFC_M_RXEN]};
    end
  end

  assign tx_load = (tst_ff == ASFC_IDLE) && txb_full_ff && tx_run;

  // Transmitter sequencer
  always_comb
  begin
    nxt_tst   = tst_ff;
    nxt_tcnt  = tcnt_ff + 16'h0001;
    nxt_tbit  = tbit_ff;
    nxt_tsh   = tsh_ff;
    nxt_tpar  = tpar_ff;
    nxt_tstop = tstop_ff;
    nxt_tline = tline_ff;
    if (!tx_run)
    begin
      nxt_tst   = ASFC_IDLE;             // Disable reinitialises
      nxt_tcnt  = 16'h0000;
      nxt_tline = 1'b1;
    end
    else
      case (tst_ff)
        ASFC_IDLE:
        begin
          nxt_tcnt  = 16'h0000;
          nxt_tline = 1'b1;              // Idle high
          if (tx_load)
          begin
            nxt_tst   = ASFC_START;
            nxt_tsh   = txb_ff;
            nxt_tbit  = 3'h0;
            nxt_tpar  = 1'b0;
            nxt_tline = 1'b0;            // Start bit
          end
        end
        ASFC_START, ASFC_DATA:
          if (tcnt_ff == FULL)
          begin
            nxt_tcnt = 16'h0000;
            if (tst_ff == ASFC_DATA
                && tbit_ff == (mode_ff[`ASFC_M_CHAR8] ? 3'h7 : 3'h6))
            begin
              nxt_tstop = mode_ff[`ASFC_M_STOP2];
              case (par_mode)
                ASFC_PAR_NONE:
                begin
                  nxt_tst   = ASFC_STOP;
                  nxt_tline = 1'b1;
                end
                ASFC_PAR_ZERO:
                begin
                  nxt_tst   = ASFC_PAR;
                  nxt_tline = 1'b0;
                end
                ASFC_PAR_ODD:
                begin
                  nxt_tst   = ASFC_PAR;
                  nxt_tline = !tpar_ff;
                end
                default:
                begin
                  nxt_tst   = ASFC_PAR;
                  nxt_tline = tpar_ff;
                end
              endcase
            end
            else
            begin
              nxt_tst   = ASFC_DATA;
              nxt_tline = tsh_ff[0];     // LSB first
              nxt_tpar  = tpar_ff ^ tsh_ff[0];
              nxt_tsh   = {1'b0, tsh_ff[7:1]};
              nxt_tbit  = (tst_ff == ASFC_DATA) ? tbit_ff + 3'h1 : 3'h0;
            end
          end
        ASFC_PAR:
          if (tcnt_ff == FULL)
          begin
            nxt_tcnt  = 16'h0000;
            nxt_tst   = ASFC_STOP;
            nxt_tline = 1'b1;
          end
        ASFC_STOP:
          if (tcnt_ff == FULL)
          begin
            nxt_tcnt = 16'h0000;
            if (tstop_ff)
              nxt_tstop = 1'b0;          // Second stop bit
            else
              nxt_tst = ASFC_IDLE;
          end
        default:
          nxt_tst = ASFC_IDLE;
      endcase
  end

  // Pin routing outputs
  always_comb
  begin
    nxt_ptx  = alt_route(sw_ff) ? 1'b1 : tline_ff;
    nxt_atx  = alt_route(sw_ff) ? tline_ff : 1'b1;
    nxt_cap  = sw_ff[`ASFC_I_CAPT_SEL] ? rx_line
                                       : timer_capture_pin;
    nxt_irq0 = sw_ff[`ASFC_I_IRQ0_SEL] ? rx_line
                                       : ext_irq0_pin;
  end

  // Transmitter and pin flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      tst_ff                 <= ASFC_IDLE;
      tcnt_ff                <= 16'h0000;
      tbit_ff                <= 3'h0;
      tsh_ff                 <= 8'h00;
      tpar_ff                <= 1'b0;
      tstop_ff               <= 1'b0;
      tline_ff               <= 1'b1;
      primary_tx_pin_ff      <= 1'b1;
      alternate_tx_pin_ff    <= 1'b1;
      timer_capture_input_ff <= 1'b0;
      ext_irq0_input_ff      <= 1'b0;
    end
    else
    begin
      tst_ff                 <= nxt_tst;
      tcnt_ff                <= nxt_tcnt;
      tbit_ff                <= nxt_tbit;
      tsh_ff                 <= nxt_tsh;
      tpar_ff                <= nxt_tpar;
      tstop_ff               <= nxt_tstop;
      tline_ff               <= nxt_tline;
      primary_tx_pin_ff      <= nxt_ptx;
      alternate_tx_pin_ff    <= nxt_atx;
      timer_capture_input_ff <= nxt_cap;
      ext_irq0_input_ff      <= nxt_irq0;
    end
  end
endmodule

/* sim/asfc_asserts.sv */
// Port checker for the serial frame unit, bound into its top level
`timescale 1ns/10ps
`include "asfc_cfg.svh"
module asfc_asserts import asfc_pkg::*; #(
  parameter int BIT_DIV = 16
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata_ff,
  input wire logic        primary_rx_pin,
  input wire logic        alternate_rx_pin,
  input wire logic        timer_capture_pin,
  input wire logic        ext_irq0_pin,
  input wire logic        primary_tx_pin_ff,
  input wire logic        alternate_tx_pin_ff,
  input wire logic        timer_capture_input_ff,
  input wire logic        ext_irq0_input_ff,
  input wire logic        rx_complete_irq_ff,
  input wire logic        rx_error_irq_ff
);
  logic [7:0] sw_ff;    // Shadow of the input switch register
  logic [7:0] nxt_sw;
  logic [9:0] low_ff;   // Length of the present low run on primary tx
  logic [9:0] nxt_low;
  logic       rx_route; // Receive line on the routed pin
  // Shadow follows register writes; low run counts cycles
  always_comb
  begin
    nxt_sw = sw_ff;
    if (reg_wr && reg_addr == `ASFC_SW_ADDR)
      nxt_sw = reg_wdata & 8'h33;
    nxt_low = primary_tx_pin_ff ? 10'h000 : low_ff + 10'h001;
  end
  // Helper registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sw_ff <= 8'h00;
      low_ff <= 10'h000;
    end
    else
    begin
      sw_ff <= nxt_sw;
      low_ff <= nxt_low;
    end
  end
  assign rx_route = sw_ff[4] ? alternate_rx_pin : primary_rx_pin;
  default clocking cb @(posedge ref_clk); endclocking
  sequence sw_read_s;
    reg_rd && reg_addr == `ASFC_SW_ADDR;
  endsequence
  sequence irq_s;
    rx_complete_irq_ff || rx_error_irq_ff;
  endsequence
  sw_readback_a:
    assert property (disable iff (!reset_n)
      sw_read_s |=> reg_rdata_ff == $past(sw_ff))
    else $error("switch register reads back wrong");
  capture_feed_a:
    assert property (disable iff (!reset_n) $past(reset_n) |->
      timer_capture_input_ff == ($past(sw_ff[1]) ? $past(rx_route)
      : $past(timer_capture_pin)))
    else $error("capture feed off its source");
  irq0_feed_a:
    assert property (disable iff (!reset_n) $past(reset_n) |->
      ext_irq0_input_ff == ($past(sw_ff[0]) ? $past(rx_route)
      : $past(ext_irq0_pin)))
    else $error("interrupt feed off its source");
  unrouted_idle_a:
    assert property (disable iff (!reset_n) $past(reset_n) |->
      ($past(sw_ff[4]) ? primary_tx_pin_ff : alternate_tx_pin_ff))
    else $error("unrouted transmit pin not high");
  irq_exclusive_a:
    assert property (disable iff (!reset_n)
      !(rx_complete_irq_ff && rx_error_irq_ff))
    else $error("both receive interrupts at once");
  irq_pulse_a:
    assert property (disable iff (!reset_n) irq_s |=> not irq_s)
    else $error("receive interrupt longer than a cycle");
  reset_idle_a:
    assert property (!reset_n |=> primary_tx_pin_ff &&
      alternate_tx_pin_ff && !rx_complete_irq_ff && !rx_error_irq_ff)
    else $error("outputs not idle in reset");
  bit_time_a:
    assert property (disable iff (!reset_n) $rose(primary_tx_pin_ff)
      |-> low_ff != 10'h000 && low_ff % BIT_DIV == 0)
    else $error("low run not whole bit times");
endmodule
bind asfc_top asfc_asserts #(.BIT_DIV(BIT_DIV)) u_asserts (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .primary_rx_pin(primary_rx_pin),
  .alternate_rx_pin(alternate_rx_pin),
  .timer_capture_pin(timer_capture_pin), .ext_irq0_pin(ext_irq0_pin),
  .primary_tx_pin_ff(primary_tx_pin_ff),
  .alternate_tx_pin_ff(alternate_tx_pin_ff),
  .timer_capture_input_ff(timer_capture_input_ff),
  .ext_irq0_input_ff(ext_irq0_input_ff),
  .rx_complete_irq_ff(rx_complete_irq_ff),
  .rx_error_irq_ff(rx_error_irq_ff));

/* sim/asfc_node.sv */
// Remote serial node: drives the unit's receive line, decodes its output
`timescale 1ns/10ps
module asfc_node #(
  parameter int BIT_DIV = 16
) (
  input  wire logic ref_clk,
  input  wire logic line_in,  // Routed transmit pin of the unit
  output logic      line_out  // Routed receive pin of the unit
);
  // Line rests high between frames
  initial line_out = 1'b1;
  // Parity bit for a parity code over n data bits
  function automatic logic par_of(logic [1:0] pm, logic [7:0] d, int n);
    logic p;
    p = 1'b0;
    for (int i = 0; i < n; i++)
      p = p ^ d[i];
    return (pm == 2'h2) ? ~p : ((pm == 2'h3) ? p : 1'b0);
  endfunction
  // One bit time, changed after a falling edge
  task bit_out(logic b);
    @(negedge ref_clk);
    line_out = b;
    repeat (BIT_DIV - 1) @(negedge ref_clk);
  endtask
  // Start, data low bit first, optional parity, a single stop
  task send(logic [7:0] d, int n, logic [1:0] pm, logic flip);
    bit_out(1'b0);
    for (int i = 0; i < n; i++)
      bit_out(d[i]);
    if (pm != 2'h0)
      bit_out(par_of(pm, d, n) ^ flip);
    bit_out(1'b1);
  endtask
  // Line held low for n bit times
  task brk(int n);
    @(negedge ref_clk);
    line_out = 1'b0;
    repeat (n * BIT_DIV) @(negedge ref_clk);
    line_out = 1'b1;
  endtask
  // Samples bit centres; gap is high time after the first stop centre
  task recv(int n, logic [1:0] pm, output logic [7:0] d, output logic p,
            output int gap, output logic ok);
    int k;
    d = 8'h00;
    p = 1'b0;
    gap = 0;
    k = 0;
    while (line_in && k < 40 * BIT_DIV)
    begin
      @(negedge ref_clk);
      k++;
    end
    ok = !line_in;
    repeat (BIT_DIV / 2) @(negedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_DIV) @(negedge ref_clk);
      d[i] = line_in;
    end
    if (pm != 2'h0)
    begin
      repeat (BIT_DIV) @(negedge ref_clk);
      p = line_in;
    end
    repeat (BIT_DIV) @(negedge ref_clk);
    while (line_in && gap < 4 * BIT_DIV)
    begin
      @(negedge ref_clk);
      gap++;
    end
  endtask
endmodule

/* sim/tb.sv */
// Bench for the serial frame unit: registers, frames, input switch
`timescale 1ns/10ps
`include "asfc_cfg.svh"
module tb;
  localparam int BD = 16;
  logic ref_clk, reset_n, reg_wr, reg_rd, use_alt, node_in, node_out;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff, cur_mode;
  logic primary_rx_pin, alternate_rx_pin, timer_capture_pin, ext_irq0_pin;
  logic primary_tx_pin_ff, alternate_tx_pin_ff, rx_complete_irq_ff;
  logic timer_capture_input_ff, ext_irq0_input_ff, rx_error_irq_ff;
  int error_cnt;
  int checked;
  // Node on the routed pair; the unrouted receive pin rests low
  assign primary_rx_pin = use_alt ? 1'b0 : node_out;
  assign alternate_rx_pin = use_alt ? node_out : 1'b0;
  assign node_in = use_alt ? alternate_tx_pin_ff : primary_tx_pin_ff;
  asfc_top #(.BIT_DIV(BD)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .primary_rx_pin(primary_rx_pin), .alternate_rx_pin(alternate_rx_pin),
    .timer_capture_pin(timer_capture_pin), .ext_irq0_pin(ext_irq0_pin),
    .primary_tx_pin_ff(primary_tx_pin_ff),
    .alternate_tx_pin_ff(alternate_tx_pin_ff),
    .timer_capture_input_ff(timer_capture_input_ff),
    .ext_irq0_input_ff(ext_irq0_input_ff),
    .rx_complete_irq_ff(rx_complete_irq_ff),
    .rx_error_irq_ff(rx_error_irq_ff));
  asfc_node #(.BIT_DIV(BD)) node (.ref_clk(ref_clk), .line_in(node_in),
    .line_out(node_out));
  // Clock at 100 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Compare and count
  task chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task results();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A wait that ran out
  task hang();
    chk(8'h00, 8'hFF);
    results();
  endtask
  // Register write and checked read, strobes changed at falling edges
  task wr(logic [15:0] a, logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task rdc(logic [15:0] a, logic [7:0] exp);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata_ff, exp);
  endtask
  // Enables off, then fields, then enables on, with pauses between
  task set_mode(logic [7:0] m);
    wr(`ASFC_MODE_ADDR, cur_mode & 8'h9F);
    repeat (3) @(negedge ref_clk);
    wr(`ASFC_MODE_ADDR, m & 8'h9F);
    repeat (3) @(negedge ref_clk);
    wr(`ASFC_MODE_ADDR, m);
    cur_mode = m;
  endtask
  task route(logic [7:0] v);
    wr(`ASFC_SW_ADDR, v);
    use_alt = v[4];
  endtask
  // Waits for a receive interrupt and checks which one came
  task wait_irq(logic exp_err);
    int k;
    k = 0;
    while (!(rx_complete_irq_ff || rx_error_irq_ff) && k < 20 * BD)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 20 * BD)
      hang();
    chk({rx_error_irq_ff, rx_complete_irq_ff}, {exp_err, ~exp_err});
  endtask
  // Reset value, unused bits, feeds from pins then from the line
  task sw_case();
    rdc(`ASFC_SW_ADDR, 8'h00);
    route(8'hCC);
    rdc(`ASFC_SW_ADDR, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk({timer_capture_input_ff, ext_irq0_input_ff}, 2'b10);
    timer_capture_pin = 1'b0;
    route(8'h13);
    repeat (2) @(negedge ref_clk);
    chk({timer_capture_input_ff, ext_irq0_input_ff}, 2'b11);
    rdc(`ASFC_SW_ADDR, 8'h13);
  endtask
  // Two frames back to back; checks data, parity and stop length
  task tx_case(logic [7:0] m, logic [7:0] d0, logic [7:0] d1);
    logic [7:0] got;
    logic [7:0] msk;
    logic p;
    logic ok;
    int gap;
    int n;
    int lo;
    n = m[2] ? 8 : 7;
    msk = m[2] ? 8'hFF : 8'h7F;
    lo = m[1] ? 3 * BD / 2 : BD / 2;
    set_mode(m);
    repeat (3) @(negedge ref_clk);
    fork
      node.recv(n, m[4:3], got, p, gap, ok);
      begin
        wr(`ASFC_TXB_ADDR, d0);
        repeat (3) @(negedge ref_clk);
        wr(`ASFC_TXB_ADDR, d1);
      end
    join
    if (!ok)
      hang();
    chk(got, d0 & msk);
    chk(p, node.par_of(m[4:3], d0, n));
    chk(gap >= lo && gap <= lo + 2, 8'h01);
    node.recv(n, m[4:3], got, p, gap, ok);
    if (!ok)
      hang();
    chk(got, d1 & msk);
    chk(p, node.par_of(m[4:3], d1, n));
  endtask
  // Two frames with one stop each; checks interrupts, data, status
  task rx_case(logic [7:0] m, logic [7:0] d, logic flip, logic e,
               logic [7:0] st);
    int n;
    n = m[2] ? 8 : 7;
    set_mode(m);
    fork
      repeat (2) node.send(d, n, m[4:3], flip);
      repeat (2)
      begin
        wait_irq(e);
        rdc(`ASFC_RXB_ADDR, d & (m[2] ? 8'hFF : 8'h7F));
      end
    join
    rdc(`ASFC_ERR_ADDR, st);
  endtask
  // Receiver enabled while the line is already low
  task low_enable();
    fork
      node.brk(9);
      begin
        set_mode(8'hA1);
        wait_irq(1'b0);
      end
    join
    rdc(`ASFC_RXB_ADDR, 8'h00);
    rdc(`ASFC_ERR_ADDR, 8'h00);
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    hang();
  end
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    use_alt = 1'b0;
    timer_capture_pin = 1'b1;
    ext_irq0_pin = 1'b0;
    cur_mode = 8'h00;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    sw_case();
    tx_case(8'hDE, 8'hA5, 8'h3C);
    rx_case(8'hBE, 8'h5A, 1'b1, 1'b1, 8'h04);
    route(8'h00);
    tx_case(8'hC6, 8'h81, 8'h7E);
    tx_case(8'hCC, 8'h0F, 8'hF0);
    tx_case(8'hD0, 8'hDB, 8'h24);
    tx_case(8'hDE, 8'h96, 8'h69);
    rx_case(8'hBF, 8'hC3, 1'b1, 1'b0, 8'h04);
    rx_case(8'hAC, 8'h3C, 1'b1, 1'b0, 8'h00);
    rx_case(8'hB2, 8'hFF, 1'b0, 1'b0, 8'h00);
    rx_case(8'hA4, 8'h81, 1'b0, 1'b0, 8'h00);
    low_enable();
    rdc(16'hFF00, 8'h00);
    results();
  end
endmodule
